/* File: common/afs_mem_if.sv */
`timescale 1ns/1ps
interface afs_mem_if #(
	parameter int DW = 64,
	parameter int AW = 2
);
	logic we;
	logic [AW-1:0] waddr;
	logic [DW-1:0] wdata;
	logic re;
	logic [AW-1:0] raddr;
	logic [DW-1:0] rdata;

	modport ctl (output we, output waddr, output wdata, output re, output raddr, input rdata);
	modport mem (input we, input waddr, input wdata, input re, input raddr, output rdata);
endinterface

/* File: common/afs_pkg.sv */
package afs_pkg;

	// ----------------------------------------------------------------
	// widths and storage
	// ----------------------------------------------------------------
	localparam int DATA_W = 64;
	localparam int NUM_REGS = 4;
	localparam int IDX_W = 2;
	localparam logic [63:0] REG_RESET = 64'h0000_0000_0000_0000;
	// every bit is reserved-as-zero, so no bit may ever be stored
	localparam logic [63:0] REG_WR_MASK = 64'h0000_0000_0000_0000;

	// ----------------------------------------------------------------
	// instruction encoding fields
	// ----------------------------------------------------------------
	localparam logic [1:0] ENC_OP0 = 2'h3;
	localparam logic [2:0] ENC_OP1_L1 = 3'h0;
	localparam logic [2:0] ENC_OP1_ALIAS = 3'h5;
	localparam logic [2:0] ENC_OP1_L3 = 3'h6;
	localparam logic [3:0] ENC_CRN = 4'h5;
	localparam logic [3:0] ENC_CRM = 4'h1;
	localparam logic [2:0] ENC_OP2_INST0 = 3'h0;
	localparam logic [2:0] ENC_OP2_INST1 = 3'h1;

	// ----------------------------------------------------------------
	// trap, redirect and nested-virtualization constants
	// ----------------------------------------------------------------
	localparam logic [5:0] SYNDROME_CLASS_SYSREG = 6'h18;
	localparam logic [5:0] SYNDROME_NONE = 6'h00;
	localparam logic [11:0] NESTED_VIRT_MEMORY_SLOT_SLOT_INST0 = 12'h128;
	localparam logic [11:0] NESTED_VIRT_MEMORY_SLOT_SLOT_INST1 = 12'h130;
	localparam logic [11:0] NESTED_VIRT_MEMORY_SLOT_SLOT_NONE = 12'h000;
	// nested-virtualization bits ordered second, first, base
	localparam logic [2:0] NV_REDIRECT_L1 = 3'h7;
	localparam logic [2:0] NV_REDIRECT_ALIAS = 3'h5;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		EL_USER = 2'b00,
		EL_KERNEL = 2'b01,
		EL_HYP = 2'b10,
		EL_MON = 2'b11
	} afs_el_t;

	typedef enum logic [2:0] {
		ROUTE_NONE = 3'b000,
		ROUTE_UNDEF = 3'b001,
		ROUTE_TRAP = 3'b010,
		ROUTE_NESTED_VIRT_MEMORY_SLOT = 3'b011,
		ROUTE_REG = 3'b100,
		ROUTE_LVL2 = 3'b101
	} afs_route_t;

	typedef enum logic [1:0] {
		FAM_NONE = 2'b00,
		FAM_L1 = 2'b01,
		FAM_ALIAS = 2'b10,
		FAM_L3 = 2'b11
	} afs_fam_t;

endpackage

/* File: design/afs_decode.sv */
`timescale 1ns/1ps
module afs_decode (
	input wire logic [1:0] op0, // instruction op0 field
	input wire logic [2:0] op1, // instruction op1 field
	input wire logic [3:0] crn, // instruction CRn field
	input wire logic [3:0] crm, // instruction CRm field
	input wire logic [2:0] op2, // instruction op2 field
	output afs_pkg::afs_fam_t fam, // register family hit
	output logic inst // instance 0 or 1
);

	// ----------------------------------------------------------------
	// common encoding match
	// ----------------------------------------------------------------
	logic base_hit;
	logic op2_hit;

	// only op1 and op2 vary across the six encodings served here
	assign base_hit = (op0 == afs_pkg::ENC_OP0) && (crn == afs_pkg::ENC_CRN) &&
		(crm == afs_pkg::ENC_CRM);
	assign op2_hit = (op2 == afs_pkg::ENC_OP2_INST0) || (op2 == afs_pkg::ENC_OP2_INST1);
	assign inst = (op2 == afs_pkg::ENC_OP2_INST1);

	// family select by op1
	always_comb begin
		fam = afs_pkg::FAM_NONE;
		if (base_hit && op2_hit) begin
			if (op1 == afs_pkg::ENC_OP1_L1) begin
				fam = afs_pkg::FAM_L1;
			end else if (op1 == afs_pkg::ENC_OP1_ALIAS) begin
				fam = afs_pkg::FAM_ALIAS;
			end else if (op1 == afs_pkg::ENC_OP1_L3) begin
				fam = afs_pkg::FAM_L3;
			end
		end
	end
endmodule

/* File: design/afs_regs.sv */
`timescale 1ns/1ps
module afs_regs #(
	parameter int DATA_W = 64,
	parameter int DEPTH = 4,
	parameter int AW = 2,
	parameter logic [63:0] WR_MASK = afs_pkg::REG_WR_MASK
) (
	input wire logic clk, // core clock
	input wire logic rstn, // async reset, active low
	afs_mem_if.mem bus // write and read port
);

	// ----------------------------------------------------------------
	// parameter checks
	// ----------------------------------------------------------------
	if (DATA_W != 64 || DEPTH != (1 << AW)) begin : g_bad_param
		$error("afs_regs: width must be 64 and depth must equal 2**AW");
	end

	logic [DATA_W-1:0] store_r [DEPTH];

	// ----------------------------------------------------------------
	// one storage word per register
	// ----------------------------------------------------------------
	for (genvar e = 0; e < DEPTH; e++) begin : g_word
		// reserved bits are masked off so they always read as zero
		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				store_r[e] <= afs_pkg::REG_RESET[DATA_W-1:0];
			end else if (bus.we && (bus.waddr == AW'(e))) begin
				store_r[e] <= bus.wdata & WR_MASK[DATA_W-1:0];
			end
		end
	end

	// registered read; a cycle without a read returns zero so refused
	// reads never leak old data toward the destination register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bus.rdata <= '0;
		end else if (bus.re) begin
			bus.rdata <= store_r[bus.raddr];
		end else begin
			bus.rdata <= '0;
		end
	end
endmodule

/* File: design/afs_top.sv */
`timescale 1ns/1ps
// What this block does
// - any access issued at level 0 is undefined, registers untouched
// - level-1 read traps to level 2 when trap-reads bit set, first
// - level-1 write traps to level 2 when trap-writes bit set, first
// - else level-1 read traps when fine-grained enable and read bit set
// - else level-1 write traps when fine-grained enable and write bit set
// - else nested bits 111 redirect level-1 access to slot 0x128 or 0x130
// - at level 2 the level-1 encoding reaches level-2 register if host bit
// - at level 3 the level-1 encoding reaches level-1 register directly
// - alias access at level 1 with nested bits 101 goes to memory slot
// - else alias at level 1 traps if base nested bit, undefined otherwise
// - alias at level 2 needs host bit; level 3 needs level 2 too
// - level-3 registers are undefined below level 3, direct at level 3
// - every register is 64 bits, all reserved zero, reset to zero
// - level-1 decode 3/0/5/1/inst; alias uses op1 value 5
// - level-3 decode 3/6/5/1 with op2 selecting instance
module afs_top (
	input wire logic clk, // core clock, 10 MHz
	input wire logic rstn, // async reset, active low
	input wire logic req_valid, // system register instruction issued
	input wire logic req_write, // 1 write instruction, 0 read instruction
	input wire logic [1:0] req_op0, // op0 field
	input wire logic [2:0] req_op1, // op1 field
	input wire logic [3:0] req_crn, // CRn field
	input wire logic [3:0] req_crm, // CRm field
	input wire logic [2:0] req_op2, // op2 field
	input wire logic [63:0] req_wdata, // source general register value
	input wire logic [1:0] current_exception_level, // issuing level
	input wire logic el2_enabled, // level 2 enabled in this security state
	input wire logic hyp_trap_vm_reads, // hypervisor trap reads bit
	input wire logic hyp_trap_vm_writes, // hypervisor trap writes bit
	input wire logic nested_virt_base, // nested virtualization base bit
	input wire logic nested_virt_first, // nested virtualization first bit
	input wire logic nested_virt_second, // nested virtualization second bit
	input wire logic host_extension_enable, // host extension bit
	input wire logic fine_grained_trap_enable, // monitor fine-grained enable
	input wire logic [1:0] fine_grained_read_trap_bits, // per instance
	input wire logic [1:0] fine_grained_write_trap_bits, // per instance
	output logic rsp_valid, // outcome ready, one-cycle pulse
	output afs_pkg::afs_route_t rsp_route, // outcome class
	output logic [63:0] rsp_rdata, // read data, zero unless a register read
	output logic [5:0] rsp_syndrome_class, // trap class or zero
	output logic nested_virt_memory_slot_valid, // memory-backed slot access, pulse
	output logic nested_virt_memory_slot_write, // slot access is a write
	output logic [11:0] nested_virt_memory_slot_offset, // slot offset
	output logic [63:0] nested_virt_memory_slot_wdata, // slot write data
	output logic lvl2_valid, // level-2 register access, pulse
	output logic lvl2_write, // level-2 access is a write
	output logic lvl2_inst, // level-2 register instance
	output logic [63:0] lvl2_wdata // level-2 write data
);

	// ----------------------------------------------------------------
	// encoding decode
	// ----------------------------------------------------------------
	afs_pkg::afs_fam_t fam;
	logic inst;

	afs_decode u_decode (
		.op0(req_op0),
		.op1(req_op1),
		.crn(req_crn),
		.crm(req_crm),
		.op2(req_op2),
		.fam(fam),
		.inst(inst)
	);

	// ----------------------------------------------------------------
	// access resolution
	// ----------------------------------------------------------------
	afs_pkg::afs_el_t el;
	afs_pkg::afs_route_t route;
	logic [2:0] nv_bits;
	logic vm_trap;
	logic fg_trap;
	logic is_l3_reg;

	assign el = afs_pkg::afs_el_t'(current_exception_level);
	assign nv_bits = {nested_virt_second, nested_virt_first, nested_virt_base};
	// trap-reads guards reads only, trap-writes guards writes only
	assign vm_trap = req_write ? hyp_trap_vm_writes : hyp_trap_vm_reads;
	assign fg_trap = fine_grained_trap_enable &
		(req_write ? fine_grained_write_trap_bits[inst] : fine_grained_read_trap_bits[inst]);

	// priority chains mirror the access checks, earliest check wins
	always_comb begin
		route = afs_pkg::ROUTE_NONE;
		is_l3_reg = 1'b0;
		case (fam)
			afs_pkg::FAM_L1: begin
				case (el)
					afs_pkg::EL_USER: begin
						route = afs_pkg::ROUTE_UNDEF;
					end
					afs_pkg::EL_KERNEL: begin
						if (el2_enabled && vm_trap) begin
							route = afs_pkg::ROUTE_TRAP;
						end else if (el2_enabled && fg_trap) begin
							route = afs_pkg::ROUTE_TRAP;
						end else if (el2_enabled && nv_bits == afs_pkg::NV_REDIRECT_L1) begin
							route = afs_pkg::ROUTE_NESTED_VIRT_MEMORY_SLOT;
						end else begin
							route = afs_pkg::ROUTE_REG;
						end
					end
					afs_pkg::EL_HYP: begin
						route = host_extension_enable ? afs_pkg::ROUTE_LVL2 : afs_pkg::ROUTE_REG;
					end
					default: begin
						route = afs_pkg::ROUTE_REG;
					end
				endcase
			end
			afs_pkg::FAM_ALIAS: begin
				case (el)
					afs_pkg::EL_USER: begin
						route = afs_pkg::ROUTE_UNDEF;
					end
					afs_pkg::EL_KERNEL: begin
						if (el2_enabled && nv_bits == afs_pkg::NV_REDIRECT_ALIAS) begin
							route = afs_pkg::ROUTE_NESTED_VIRT_MEMORY_SLOT;
						end else if (el2_enabled && nested_virt_base) begin
							route = afs_pkg::ROUTE_TRAP;
						end else begin
							route = afs_pkg::ROUTE_UNDEF;
						end
					end
					afs_pkg::EL_HYP: begin
						route = host_extension_enable ? afs_pkg::ROUTE_REG : afs_pkg::ROUTE_UNDEF;
					end
					default: begin
						if (el2_enabled && host_extension_enable) begin
							route = afs_pkg::ROUTE_REG;
						end else begin
							route = afs_pkg::ROUTE_UNDEF;
						end
					end
				endcase
			end
			afs_pkg::FAM_L3: begin
				is_l3_reg = 1'b1;
				if (el == afs_pkg::EL_MON) begin
					route = afs_pkg::ROUTE_REG;
				end else begin
					route = afs_pkg::ROUTE_UNDEF;
				end
			end
			default: begin
				route = afs_pkg::ROUTE_NONE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// register storage
	// ----------------------------------------------------------------
	afs_mem_if #(.DW(afs_pkg::DATA_W), .AW(afs_pkg::IDX_W)) mem_bus ();

	logic reg_hit;
	logic [afs_pkg::IDX_W-1:0] reg_idx;

	assign reg_hit = req_valid && (route == afs_pkg::ROUTE_REG);
	// index is {level-3 family, instance}
	assign reg_idx = {is_l3_reg, inst};

	// only a resolved register access touches storage
	assign mem_bus.we = reg_hit && req_write;
	assign mem_bus.waddr = reg_idx;
	assign mem_bus.wdata = req_wdata;
	assign mem_bus.re = reg_hit && !req_write;
	assign mem_bus.raddr = reg_idx;

	afs_regs #(
		.DATA_W(afs_pkg::DATA_W),
		.DEPTH(afs_pkg::NUM_REGS),
		.AW(afs_pkg::IDX_W),
		.WR_MASK(afs_pkg::REG_WR_MASK)
	) u_regs (
		.clk(clk),
		.rstn(rstn),
		.bus(mem_bus.mem)
	);

	// read data leaves straight from the storage read flop
	assign rsp_rdata = mem_bus.rdata;

	// ----------------------------------------------------------------
	// outcome stage
	// ----------------------------------------------------------------
	// one outcome per request, one cycle later; back-to-back allowed
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rsp_valid <= 1'b0;
			rsp_route <= afs_pkg::ROUTE_NONE;
			rsp_syndrome_class <= afs_pkg::SYNDROME_NONE;
		end else begin
			rsp_valid <= req_valid;
			rsp_route <= req_valid ? route : afs_pkg::ROUTE_NONE;
			if (req_valid && route == afs_pkg::ROUTE_TRAP) begin
				rsp_syndrome_class <= afs_pkg::SYNDROME_CLASS_SYSREG;
			end else begin
				rsp_syndrome_class <= afs_pkg::SYNDROME_NONE;
			end
		end
	end

	// ----------------------------------------------------------------
	// memory-backed slot redirect
	// ----------------------------------------------------------------
	// the slot lives outside; data is zeroed when idle to keep it quiet
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			nested_virt_memory_slot_valid <= 1'b0;
			nested_virt_memory_slot_write <= 1'b0;
			nested_virt_memory_slot_offset <= afs_pkg::NESTED_VIRT_MEMORY_SLOT_SLOT_NONE;
			nested_virt_memory_slot_wdata <= '0;
		end else if (req_valid && route == afs_pkg::ROUTE_NESTED_VIRT_MEMORY_SLOT) begin
			nested_virt_memory_slot_valid <= 1'b1;
			nested_virt_memory_slot_write <= req_write;
			nested_virt_memory_slot_offset <= inst ? afs_pkg::NESTED_VIRT_MEMORY_SLOT_SLOT_INST1 : afs_pkg::NESTED_VIRT_MEMORY_SLOT_SLOT_INST0;
			nested_virt_memory_slot_wdata <= req_write ? req_wdata : '0;
		end else begin
			nested_virt_memory_slot_valid <= 1'b0;
			nested_virt_memory_slot_write <= 1'b0;
			nested_virt_memory_slot_offset <= afs_pkg::NESTED_VIRT_MEMORY_SLOT_SLOT_NONE;
			nested_virt_memory_slot_wdata <= '0;
		end
	end

	// ----------------------------------------------------------------
	// level-2 register forward
	// ----------------------------------------------------------------
	// level-2 registers are held elsewhere; this only steers the access
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lvl2_valid <= 1'b0;
			lvl2_write <= 1'b0;
			lvl2_inst <= 1'b0;
			lvl2_wdata <= '0;
		end else if (req_valid && route == afs_pkg::ROUTE_LVL2) begin
			lvl2_valid <= 1'b1;
			lvl2_write <= req_write;
			lvl2_inst <= inst;
			lvl2_wdata <= req_write ? req_wdata : '0;
		end else begin
			lvl2_valid <= 1'b0;
			lvl2_write <= 1'b0;
			lvl2_inst <= 1'b0;
			lvl2_wdata <= '0;
		end
	end
endmodule

/* File: verification/afs_slot_model.sv */
`timescale 1ns/1ps
module afs_slot_model (
	input wire logic clk, // core clock
	input wire logic rstn, // async reset, active low
	input wire logic nested_virt_memory_slot_valid, // slot access pulse
	input wire logic nested_virt_memory_slot_write, // slot write
	input wire logic [11:0] nested_virt_memory_slot_offset, // slot offset
	input wire logic [63:0] nested_virt_memory_slot_wdata, // slot write data
	output logic [63:0] slot0_r, // instance 0 slot
	output logic [63:0] slot1_r, // instance 1 slot
	output logic [15:0] wr_cnt_r // slot writes seen
);
	// the slots live outside the block; an unknown offset is dropped, not guessed
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			slot0_r <= 64'h0;
			slot1_r <= 64'h0;
			wr_cnt_r <= 16'h0;
		end else if (nested_virt_memory_slot_valid && nested_virt_memory_slot_write) begin
			if (nested_virt_memory_slot_offset == 12'h128) slot0_r <= nested_virt_memory_slot_wdata;
			if (nested_virt_memory_slot_offset == 12'h130) slot1_r <= nested_virt_memory_slot_wdata;
			wr_cnt_r <= wr_cnt_r + 16'h1;
		end
	end
endmodule

/* File: verification/afs_top_sva.sv */
`timescale 1ns/1ps
module afs_top_sva (
	input wire logic clk, // core clock
	input wire logic rstn, // async reset, active low
	input wire logic req_valid, // request issued
	input wire logic req_write, // write request
	input wire logic [1:0] req_op0, // op0 field
	input wire logic [2:0] req_op1, // op1 field
	input wire logic [3:0] req_crn, // CRn field
	input wire logic [3:0] req_crm, // CRm field
	input wire logic [2:0] req_op2, // op2 field
	input wire logic [1:0] current_exception_level, // issuing level
	input wire logic el2_enabled, // level 2 enabled
	input wire logic hyp_trap_vm_reads, // trap reads bit
	input wire logic host_extension_enable, // host bit
	input wire logic rsp_valid, // outcome pulse
	input afs_pkg::afs_route_t rsp_route, // outcome class
	input wire logic [63:0] rsp_rdata, // read data
	input wire logic [5:0] rsp_syndrome_class, // trap class
	input wire logic nested_virt_memory_slot_valid, // slot pulse
	input wire logic [11:0] nested_virt_memory_slot_offset, // slot offset
	input wire logic lvl2_valid // level-2 pulse
);
	// ----
	// served op0/CRn/CRm/op2 pattern seen this cycle, any op1
	// ----
	logic hit;
	logic [1:0] el;
	assign hit = req_valid && req_op0 == 2'h3 && req_crn == 4'h5 && req_crm == 4'h1
		&& req_op2[2:1] == 2'h0;
	assign el = current_exception_level;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	lvl0_undef_a: assert property (hit && el == 2'h0 && req_op1 inside {3'h0, 3'h5, 3'h6}
		|=> rsp_valid && rsp_route == afs_pkg::ROUTE_UNDEF) else $error("level 0 not undefined");
	read_trap_a: assert property (hit && req_op1 == 3'h0 && !req_write && el == 2'h1
		&& el2_enabled && hyp_trap_vm_reads |=> rsp_route == afs_pkg::ROUTE_TRAP)
		else $error("read trap missed");
	trap_class_a: assert property (rsp_valid |-> rsp_syndrome_class ==
		((rsp_route == afs_pkg::ROUTE_TRAP) ? 6'h18 : 6'h00)) else $error("bad class");
	slot_offset_a: assert property (hit |=> !nested_virt_memory_slot_valid
		|| nested_virt_memory_slot_offset == ($past(req_op2[0]) ? 12'h130 : 12'h128)) else $error("bad slot");
	lvl3_direct_a: assert property (hit && req_op1 == 3'h0 && el == 2'h3
		|=> rsp_route == afs_pkg::ROUTE_REG) else $error("level 3 not direct");
	lvl2_host_a: assert property (hit && req_op1 == 3'h0 && el == 2'h2 && host_extension_enable
		|=> lvl2_valid && rsp_route == afs_pkg::ROUTE_LVL2) else $error("no level 2 access");
	alias_host_a: assert property (hit && req_op1 == 3'h5 && el == 2'h2 && !host_extension_enable
		|=> rsp_route == afs_pkg::ROUTE_UNDEF) else $error("alias not undefined");
	l3_below_a: assert property (hit && req_op1 == 3'h6 && el != 2'h3
		|=> rsp_route == afs_pkg::ROUTE_UNDEF && !nested_virt_memory_slot_valid && !lvl2_valid)
		else $error("level 3 register reached");
	rdata_zero_a: assert property (rsp_valid |-> rsp_rdata == 64'h0) else $error("rdata");
	side_pulse_a: assert property (rsp_valid |-> nested_virt_memory_slot_valid == (rsp_route == afs_pkg::ROUTE_NESTED_VIRT_MEMORY_SLOT)
		&& lvl2_valid == (rsp_route == afs_pkg::ROUTE_LVL2)) else $error("stray pulse");
endmodule

bind afs_top afs_top_sva u_sva (.clk, .rstn, .req_valid, .req_write, .req_op0, .req_op1,
	.req_crn, .req_crm, .req_op2, .current_exception_level, .el2_enabled, .hyp_trap_vm_reads,
	.host_extension_enable, .rsp_valid, .rsp_route, .rsp_rdata, .rsp_syndrome_class,
	.nested_virt_memory_slot_valid, .nested_virt_memory_slot_offset, .lvl2_valid);

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	// ----
	// signals
	// ----
	logic clk, rstn, req_valid, req_write, el2_enabled, hyp_trap_vm_reads, hyp_trap_vm_writes;
	logic nested_virt_base, nested_virt_first, nested_virt_second, host_extension_enable;
	logic fine_grained_trap_enable, rsp_valid, nested_virt_memory_slot_valid, nested_virt_memory_slot_write, lvl2_valid;
	logic lvl2_write, lvl2_inst, e_v, e_w, e_i;
	logic [1:0] req_op0, current_exception_level;
	logic [1:0] fine_grained_read_trap_bits, fine_grained_write_trap_bits;
	logic [2:0] req_op1, req_op2;
	logic [3:0] req_crn, req_crm;
	logic [5:0] rsp_syndrome_class;
	logic [11:0] nested_virt_memory_slot_offset;
	logic [15:0] wr_cnt_r, exp_cnt;
	logic [63:0] req_wdata, rsp_rdata, nested_virt_memory_slot_wdata, lvl2_wdata, slot0_r, slot1_r, exp0, exp1, e_d;
	logic [95:0] stim;
	logic [31:0] r, q;
	logic [2:0] tab [4];
	afs_pkg::afs_route_t rsp_route, e_route;
	integer seed;
	int error_cnt = 0;
	int samples_checked = 0;
	int cyc = 0;
	int n;

	// one packed vector so every input has a value at time zero
	assign {req_valid, req_write, req_op0, req_op1, req_crn, req_crm, req_op2,
		current_exception_level, el2_enabled, hyp_trap_vm_reads, hyp_trap_vm_writes,
		nested_virt_base, nested_virt_first, nested_virt_second, host_extension_enable,
		fine_grained_trap_enable, fine_grained_read_trap_bits, fine_grained_write_trap_bits,
		req_wdata} = stim;

	afs_top DUT (.clk, .rstn, .req_valid, .req_write, .req_op0, .req_op1, .req_crn, .req_crm,
		.req_op2, .req_wdata, .current_exception_level, .el2_enabled, .hyp_trap_vm_reads,
		.hyp_trap_vm_writes, .nested_virt_base, .nested_virt_first, .nested_virt_second,
		.host_extension_enable, .fine_grained_trap_enable, .fine_grained_read_trap_bits,
		.fine_grained_write_trap_bits, .rsp_valid, .rsp_route, .rsp_rdata, .rsp_syndrome_class,
		.nested_virt_memory_slot_valid, .nested_virt_memory_slot_write, .nested_virt_memory_slot_offset, .nested_virt_memory_slot_wdata, .lvl2_valid, .lvl2_write,
		.lvl2_inst, .lvl2_wdata);
	afs_slot_model slots (.clk, .rstn, .nested_virt_memory_slot_valid, .nested_virt_memory_slot_write, .nested_virt_memory_slot_offset, .nested_virt_memory_slot_wdata,
		.slot0_r, .slot1_r, .wr_cnt_r);

	always #50 clk = ~clk;

	// ----
	// expectation from the access checks, in their priority order
	// ----
	function automatic afs_pkg::afs_route_t exp_route();
		logic [1:0] el;
		logic [2:0] nv;
		logic h;
		el = current_exception_level;
		nv = {nested_virt_second, nested_virt_first, nested_virt_base};
		h = host_extension_enable;
		if (req_op0 != 2'h3 || req_crn != 4'h5 || req_crm != 4'h1 || req_op2[2:1] != 2'h0
			|| !(req_op1 inside {3'h0, 3'h5, 3'h6})) return afs_pkg::ROUTE_NONE;
		if (el == 2'h0) return afs_pkg::ROUTE_UNDEF;
		if (req_op1 == 3'h6) return el == 2'h3 ? afs_pkg::ROUTE_REG : afs_pkg::ROUTE_UNDEF;
		if (req_op1 == 3'h5) begin
			if (el == 2'h2) return h ? afs_pkg::ROUTE_REG : afs_pkg::ROUTE_UNDEF;
			if (el == 2'h3) return el2_enabled && h ? afs_pkg::ROUTE_REG : afs_pkg::ROUTE_UNDEF;
			if (el2_enabled && nv == 3'h5) return afs_pkg::ROUTE_NESTED_VIRT_MEMORY_SLOT;
			return el2_enabled && nv[0] ? afs_pkg::ROUTE_TRAP : afs_pkg::ROUTE_UNDEF;
		end
		if (el == 2'h3) return afs_pkg::ROUTE_REG;
		if (el == 2'h2) return h ? afs_pkg::ROUTE_LVL2 : afs_pkg::ROUTE_REG;
		if (el2_enabled && (req_write ? hyp_trap_vm_writes : hyp_trap_vm_reads))
			return afs_pkg::ROUTE_TRAP;
		if (el2_enabled && fine_grained_trap_enable && (req_write ?
			fine_grained_write_trap_bits[req_op2[0]] : fine_grained_read_trap_bits[req_op2[0]]))
			return afs_pkg::ROUTE_TRAP;
		if (el2_enabled && nv == 3'h7) return afs_pkg::ROUTE_NESTED_VIRT_MEMORY_SLOT;
		return afs_pkg::ROUTE_REG;
	endfunction

	function automatic logic [31:0] req(logic w, logic [2:0] o1, logic o2, logic [1:0] el,
		logic [11:0] ctl);
		return {1'b1, w, 2'h3, o1, 4'h5, 4'h1, 2'h0, o2, el, ctl};
	endfunction

	task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string msg);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %0t %s seen %0h exp %0h", $time, msg, seen, exp);
		end
	endtask

	task automatic drive(input logic [31:0] s, input logic [63:0] d);
		@(posedge clk);
		stim <= {s, d};
	endtask

	task automatic print_verdict();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// inputs as the design takes them at this edge
	always @(posedge clk) begin
		e_v = req_valid && rstn;
		e_route = exp_route();
		e_w = req_write;
		e_i = req_op2[0];
		e_d = req_wdata;
		cyc++;
		if (cyc == 4000) begin
			error_cnt++;
			print_verdict();
		end
	end

	// outputs stand one cycle, so they are judged half a cycle after launch
	always @(negedge clk) begin
		if (!rstn) begin
			exp_cnt = 16'h0;
			exp0 = 64'h0;
			exp1 = 64'h0;
		end else begin
			check(rsp_valid, e_v, "valid");
			check(rsp_rdata, 64'h0, "rdata");
			if (e_v) begin
				check(rsp_route, e_route, "route");
				check(rsp_syndrome_class, e_route == afs_pkg::ROUTE_TRAP ? 6'h18 : 6'h00, "class");
				check(nested_virt_memory_slot_valid, e_route == afs_pkg::ROUTE_NESTED_VIRT_MEMORY_SLOT, "slot");
				check(lvl2_valid, e_route == afs_pkg::ROUTE_LVL2, "lvl2");
				if (e_route == afs_pkg::ROUTE_NESTED_VIRT_MEMORY_SLOT) check(nested_virt_memory_slot_offset, e_i ? 12'h130 : 12'h128, "off");
				if (e_route == afs_pkg::ROUTE_LVL2 && e_w) check(lvl2_wdata, e_d, "l2 data");
				if (e_route == afs_pkg::ROUTE_NESTED_VIRT_MEMORY_SLOT) check(nested_virt_memory_slot_write, e_w, "slot kind");
				// the far register needs kind and instance, not only the pulse
				if (e_route == afs_pkg::ROUTE_LVL2) begin
					check(lvl2_write, e_w, "l2 kind");
					check(lvl2_inst, e_i, "l2 inst");
				end
				if (e_route == afs_pkg::ROUTE_NESTED_VIRT_MEMORY_SLOT && e_w) begin
					exp_cnt = exp_cnt + 16'h1;
					if (e_i) exp1 = e_d;
					else exp0 = e_d;
				end
			end else begin
				// no request taken, so no outcome and no side pulse may show
				check({rsp_route, nested_virt_memory_slot_valid, lvl2_valid}, '0, "idle");
			end
		end
	end

	initial begin
		clk = 1'b0;
		rstn = 1'b0;
		stim = '0;
		seed = 32'hb11be1d5;
		tab = '{3'h0, 3'h5, 3'h6, 3'h2};
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		// hand cases: all traps at once, fine-grained alone, both redirects, host
		drive(req(1'b0, 3'h6, 1'b0, 2'h3, 12'h000), 64'h0);
		drive(req(1'b1, 3'h0, 1'b0, 2'h1, 12'hFFF), 64'h0123_4567_89AB_CDEF);
		drive(req(1'b0, 3'h0, 1'b1, 2'h1, 12'h818), 64'h0);
		drive(req(1'b1, 3'h0, 1'b1, 2'h1, 12'h9C0), 64'hFEDC_BA98_7654_3210);
		drive(req(1'b1, 3'h5, 1'b0, 2'h1, 12'h940), 64'h5A5A_0F0F_A5A5_F0F0);
		drive(req(1'b1, 3'h0, 1'b1, 2'h2, 12'h020), 64'h1111_2222_3333_4444);
		// every level against every family, both kinds and both instances
		for (n = 0; n < 48; n++) begin
			q = $random(seed);
			drive(req(n[0], tab[(n / 4) % 3], n[1], 2'(n / 12), q[11:0]), {q, ~q});
		end
		// random traffic, mostly the served op0/CRn/CRm pattern, back to back
		for (n = 0; n < 1500; n++) begin
			r = $random(seed);
			q = $random(seed);
			if (q[2:0] != 3'h0) r[29:17] = {2'h3, tab[q[4:3]], 4'h5, 4'h1};
			if (q[5]) r[16:15] = 2'h0;
			r[31] = r[31] | q[6];
			drive(r, {q, r});
		end
		// let the last requests reach the slots before the totals are compared
		drive(32'h0, 64'h0);
		repeat (3) @(negedge clk);
		check(wr_cnt_r, exp_cnt, "slot count");
		check(slot0_r, exp0, "slot 0");
		check(slot1_r, exp1, "slot 1");
		// reset lands on the edge that answers a request
		drive(req(1'b0, 3'h6, 1'b1, 2'h3, 12'h000), 64'h0);
		@(posedge clk);
		rstn <= 1'b0;
		stim <= '0;
		@(negedge clk);
		check({rsp_valid, nested_virt_memory_slot_valid, lvl2_valid, rsp_route, rsp_syndrome_class}, '0, "reset");
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		drive(req(1'b1, 3'h0, 1'b0, 2'h3, 12'hFFF), 64'h0);
		drive(32'h0, 64'h0);
		repeat (2) @(posedge clk);
		print_verdict();
	end
endmodule
